// [tape_command_interface.sv]
// host-facing command interpreter of the cartridge tape module
`timescale 1ns/1ps
`include "tape_cmd_defines.svh"
module tape_command_interface (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// operating mode straps
	input wire tape_cmd_pkg::mode_t i_mode,
	// host bus access
	input wire tape_cmd_pkg::host_req_t i_host,
	output logic [7:0] o_rdata,
	output logic o_end_of_function_interrupt,
	output logic o_dma_request,
	// drive side: execution handshake and data stream
	output logic o_func_start,
	output logic [7:0] o_func_code,
	input wire logic i_func_done,
	input wire logic [7:0] i_drive_status,
	input wire logic i_drive_data_valid,
	input wire logic [7:0] i_drive_data,
	output logic o_drive_data_ready,
	output logic o_drive_data_valid,
	output logic [7:0] o_drive_data,
	input wire logic i_drive_data_ready
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_PARAM, ST_EXEC, ST_XFER, ST_SENSE
	} state_t;

	state_t state_r, state_nxt;
	logic [7:0] cmd_r;
	logic [2:0] par_left_r;
	logic [2:0] sense_left_r;
	logic [7:0] obuf_r;
	logic out_full_r;
	logic in_full_r;
	logic spec_pend_r;
	logic spec_start_r;
	logic err_r;
	logic xfer_on_r;
	logic is_write_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic drq_r;
	logic start_r;

	// decode of a command code for the strapped drive type
	function automatic tape_cmd_pkg::cmd_kind_t kind_of(input logic [7:0] c, input logic b);
		case (c)
			`OP_RESET, `OP_INIT, `OP_FILE_MARK, `OP_READ_STATUS:
				kind_of = tape_cmd_pkg::KIND_SIMPLE;
			`OP_WRITE_BLOCK, `OP_READ_BLOCK: kind_of = tape_cmd_pkg::KIND_DATA;
			`OP_SPACE_FILE, `OP_REWIND, `OP_RETENSION, `OP_ERASE:
				kind_of = b ? tape_cmd_pkg::KIND_BAD : tape_cmd_pkg::KIND_SIMPLE;
			`OP_UNLOAD, `OP_CONTINUE, `OP_VERIFY:
				kind_of = b ? tape_cmd_pkg::KIND_SIMPLE : tape_cmd_pkg::KIND_BAD;
			`OP_WRITE_RAM, `OP_READ_RAM:
				kind_of = b ? tape_cmd_pkg::KIND_DATA : tape_cmd_pkg::KIND_BAD;
			`OP_START_XFER, `OP_END_XFER: kind_of = tape_cmd_pkg::KIND_SPECIAL;
			default: kind_of = tape_cmd_pkg::KIND_BAD;
		endcase
	endfunction

	function automatic logic [2:0] npar_of(input logic [7:0] c, input logic b);
		case (c)
			`OP_WRITE_BLOCK, `OP_READ_BLOCK: npar_of = b ? `NPAR_THREE : `NPAR_ONE;
			`OP_WRITE_RAM, `OP_READ_RAM, `OP_VERIFY: npar_of = `NPAR_FIVE;
			default: npar_of = `NPAR_ONE;
		endcase
	endfunction

	// address decode: base 0 odd is command/status, even is parameter/drive status
	wire cmd_wr = i_host.cs_base0 && i_host.odd_addr && i_host.wr;
	wire par_wr = i_host.cs_base0 && !i_host.odd_addr && i_host.wr;
	wire ctl_rd = i_host.cs_base0 && i_host.odd_addr && i_host.rd;
	wire sns_rd = i_host.cs_base0 && !i_host.odd_addr && i_host.rd;
	wire dat_wr = i_host.cs_base1 && i_host.wr;
	wire dat_rd = i_host.cs_base1 && i_host.rd;

	wire tape_cmd_pkg::cmd_kind_t new_kind = kind_of(i_host.wdata, i_mode.drive_type_b);
	wire tape_cmd_pkg::cmd_kind_t cur_kind = kind_of(cmd_r, i_mode.drive_type_b);
	wire par_last = par_wr && (par_left_r == 3'h1);

	// write path fifo: host to drive
	logic wf_in_ready;
	logic wf_out_valid;
	logic [7:0] wf_out_data;
	tape_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_wr_fifo (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(dat_wr && xfer_on_r && is_write_r),
		.i_in_data(i_host.wdata),
		.o_in_ready(wf_in_ready),
		.o_out_valid(wf_out_valid),
		.o_out_data(wf_out_data),
		.i_out_ready(i_drive_data_ready)
	);
	assign o_drive_data_valid = wf_out_valid;
	assign o_drive_data = wf_out_data;
	// read path: drive byte held until host takes it; drive stalls meanwhile
	logic rbuf_full_r;
	logic [7:0] rbuf_r;
	logic drdy_r;
	wire rbuf_load = i_drive_data_valid && drdy_r;
	assign o_drive_data_ready = drdy_r;

	// byte readiness: room to write or a byte to read
	wire byte_ready = xfer_on_r && (is_write_r ? wf_in_ready : rbuf_full_r);

	// command sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (cmd_wr) state_nxt = ST_PARAM;
			ST_PARAM: if (par_last) state_nxt = (cur_kind == tape_cmd_pkg::KIND_DATA) ?
				ST_XFER : ST_EXEC;
			ST_EXEC: if (i_func_done || err_r) state_nxt = ST_SENSE;
			ST_XFER: if (i_func_done) state_nxt = ST_SENSE;
			ST_SENSE: if (sns_rd && out_full_r && sense_left_r == 3'h1) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			cmd_r <= 8'h00;
			par_left_r <= 3'h0;
			err_r <= 1'b0;
			is_write_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			start_r <= 1'b0;
			if (state_r == ST_IDLE && cmd_wr) begin
				cmd_r <= i_host.wdata;
				par_left_r <= npar_of(i_host.wdata, i_mode.drive_type_b);
				err_r <= (new_kind == tape_cmd_pkg::KIND_BAD) ||
					(new_kind == tape_cmd_pkg::KIND_SPECIAL);
				is_write_r <= (i_host.wdata == `OP_WRITE_BLOCK) ||
					(i_host.wdata == `OP_WRITE_RAM);
			end else if (state_r == ST_PARAM && par_wr) begin
				par_left_r <= par_left_r - 3'h1;
				if (par_last && !err_r)
					start_r <= 1'b1;
			end
		end
	end

	// special commands during a transfer: no status byte results
	// the code is held until its parameter lands, so no byte moves early
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			xfer_on_r <= 1'b0;
			spec_pend_r <= 1'b0;
			spec_start_r <= 1'b0;
		end else if (state_r != ST_XFER) begin
			xfer_on_r <= 1'b0;
			spec_pend_r <= 1'b0;
		end else if (cmd_wr) begin
			spec_pend_r <= 1'b1;
			spec_start_r <= (i_host.wdata == `OP_START_XFER);
		end else if (par_wr && spec_pend_r) begin
			spec_pend_r <= 1'b0;
			xfer_on_r <= spec_start_r;
		end
	end

	// read buffer from drive
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rbuf_full_r <= 1'b0;
			rbuf_r <= 8'h00;
			drdy_r <= 1'b0;
		end else begin
			// ready is registered, so it drops in the cycle a byte lands
			drdy_r <= xfer_on_r && !is_write_r && !rbuf_full_r && !rbuf_load;
			if (rbuf_load) begin
				rbuf_full_r <= 1'b1;
				rbuf_r <= i_drive_data;
			end else if (dat_rd) begin
				rbuf_full_r <= 1'b0;
			end
		end
	end

	// status bytes: byte 0 announces the count, then drive status, or ERR_INVALID for a rejected code
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			out_full_r <= 1'b0;
			obuf_r <= 8'h00;
			sense_left_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			irq_r <= 1'b0;
			if (state_r != ST_SENSE && state_nxt == ST_SENSE) begin
				out_full_r <= 1'b1;
				irq_r <= 1'b1;
				obuf_r <= {5'h00, `SENSE_COUNT};
				sense_left_r <= `SENSE_COUNT;
			end else if (state_r == ST_SENSE && sns_rd && out_full_r) begin
				sense_left_r <= sense_left_r - 3'h1;
				obuf_r <= err_r ? `ERR_INVALID : i_drive_status;
				out_full_r <= (sense_left_r != 3'h1);
			end
		end
	end

	// input buffer full: one cycle busy after each command or parameter byte
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			in_full_r <= 1'b0;
		else
			in_full_r <= cmd_wr || par_wr;
	end

	// host read mux and dma request
	wire [7:0] ctl_status = {3'h0, state_r != ST_IDLE, err_r, byte_ready,
		in_full_r, out_full_r};
	wire [7:0] rd_mux = ctl_rd ? ctl_status : sns_rd ? obuf_r : dat_rd ? rbuf_r : 8'h00;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rdata_r <= 8'h00;
			drq_r <= 1'b0;
		end else begin
			rdata_r <= rd_mux;
			// dropped on the cycle a byte moves, so one request moves one byte
			drq_r <= i_mode.dma_mode && byte_ready && !(dat_wr || dat_rd);
		end
	end

	assign o_rdata = rdata_r;
	assign o_end_of_function_interrupt = irq_r;
	assign o_dma_request = drq_r;
	assign o_func_start = start_r;
	assign o_func_code = cmd_r;
endmodule

// [tape_cmd_defines.svh]
// constants for the tape command interface
`ifndef TAPE_CMD_DEFINES_SVH
`define TAPE_CMD_DEFINES_SVH
`define OP_RESET 8'h00
`define OP_INIT 8'h01
`define OP_WRITE_BLOCK 8'h02
`define OP_FILE_MARK 8'h03
`define OP_READ_BLOCK 8'h04
`define OP_SPACE_FILE 8'h05
`define OP_READ_STATUS 8'h06
`define OP_REWIND 8'h07
`define OP_RETENSION 8'h08
`define OP_ERASE 8'h09
`define OP_UNLOAD 8'h0C
`define OP_CONTINUE 8'h14
`define OP_WRITE_RAM 8'h15
`define OP_READ_RAM 8'h16
`define OP_VERIFY 8'h17
`define OP_START_XFER 8'h40
`define OP_END_XFER 8'h80
`define NPAR_ONE 3'h1
`define NPAR_THREE 3'h3
`define NPAR_FIVE 3'h5
`define SENSE_COUNT 3'h2
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define BIT_OUT_FULL 0
`define BIT_IN_FULL 1
`define BIT_DRQ 2
`define BIT_ERR 3
`define BIT_BUSY 4
`define ERR_INVALID 8'h01
`endif

// [tape_cmd_pkg.sv]
// shared types for the tape command interface
package tape_cmd_pkg;
	typedef enum logic [1:0] {
		KIND_SIMPLE,
		KIND_DATA,
		KIND_SPECIAL,
		KIND_BAD
	} cmd_kind_t;
	typedef struct packed {
		logic cs_base0;
		logic cs_base1;
		logic odd_addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} host_req_t;
	typedef struct packed {
		logic drive_type_b;
		logic dma_mode;
	} mode_t;
endpackage

// [tape_fifo.sv]
// parameterised flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`include "tape_cmd_defines.svh"
module tape_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int AW = `FIFO_AW
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic room_r;
	logic avail_r;
	wire push = i_in_valid && room_r;
	wire pop = avail_r && i_out_ready;
	// flags kept in flops so both handshake outputs leave the block registered
	wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign o_in_ready = room_r;
	assign o_out_valid = avail_r;
	assign o_out_data = mem_r[rp_r];
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			room_r <= 1'b1;
			avail_r <= 1'b0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= i_in_data;
				wp_r <= wp_r + 1'b1;
			end
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_nxt;
			room_r <= (cnt_nxt != (AW+1)'(DEPTH));
			avail_r <= (cnt_nxt != '0);
		end
	end
endmodule

// [tape_cmd_monitor.sv]
// assertion checker for the tape command interface
`timescale 1ns/1ps
module tape_cmd_monitor (
	// clock, reset, mode
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire tape_cmd_pkg::mode_t i_mode,
	// host side and drive handshake
	input wire tape_cmd_pkg::host_req_t i_host,
	input wire logic i_func_done,
	input wire logic o_func_start,
	input wire logic [7:0] o_func_code,
	input wire logic o_end_of_function_interrupt,
	input wire logic o_dma_request
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	wire par_wr = i_host.cs_base0 && !i_host.odd_addr && i_host.wr;
	wire dat_acc = i_host.cs_base1 && (i_host.wr || i_host.rd);
	wire irq = o_end_of_function_interrupt;
	wire b = i_mode.drive_type_b;
	a_start_after_param: assert property (o_func_start |-> $past(par_wr))
		else $error("start without parameter");
	a_start_one_pulse: assert property (o_func_start |=> !o_func_start)
		else $error("start not a pulse");
	a_irq_on_done: assert property (i_func_done |=> irq)
		else $error("no interrupt at end");
	a_irq_one_pulse: assert property (irq |=> !irq)
		else $error("interrupt not a pulse");
	a_dma_mode_only: assert property (o_dma_request |-> i_mode.dma_mode)
		else $error("dma request in polled mode");
	a_dma_drop_access: assert property (dat_acc |=> !o_dma_request)
		else $error("dma request held over access");
	a_type_b_codes: assert property (o_func_start && b |->
		!(o_func_code inside {8'h05, 8'h07, 8'h08, 8'h09})) else $error("bad code type b");
	a_type_a_codes: assert property (o_func_start && !b |->
		!(o_func_code inside {8'h0C, 8'h14, 8'h15, 8'h16, 8'h17})) else $error("bad code type a");
	cover property (irq);
	cover property (o_dma_request);
	cover property (o_func_start && b);
endmodule
bind tape_command_interface tape_cmd_monitor mon (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_mode(i_mode), .i_host(i_host), .i_func_done(i_func_done), .o_func_start(o_func_start),
	.o_func_code(o_func_code), .o_end_of_function_interrupt(o_end_of_function_interrupt),
	.o_dma_request(o_dma_request));

// [tape_host_model.sv]
// host board model driving the command and data ports
`timescale 1ns/1ps
`include "tape_cmd_defines.svh"
module tape_host_model (
	// clock and answers
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	input wire logic i_dma_request,
	// bus request
	output tape_cmd_pkg::host_req_t o_req
);
	logic [7:0] q;
	int stalls = 0;
	initial o_req = '0;
	// k holds cs0, cs1, odd, wr, rd
	task automatic acc(input logic [4:0] k, input logic [7:0] d);
		@(posedge i_clock);
		#1 o_req = {k, d};
		@(posedge i_clock);
		#1 q = i_rdata;
		o_req = '0;
	endtask
	task automatic wait_flag(input int n, input logic v);
		for (int i = 0; i < 200; i++) begin
			acc(5'h15, 8'h00);
			if (q[n] === v) break;
		end
		// a flag that never comes counts against the run
		if (q[n] !== v) stalls++;
	endtask
	task automatic send(input logic [7:0] c, input int n, input logic [7:0] p);
		wait_flag(`BIT_IN_FULL, 1'b0);
		acc(5'h16, c);
		repeat (n) begin
			wait_flag(`BIT_IN_FULL, 1'b0);
			acc(5'h12, p);
		end
	endtask
	task automatic sense(output logic [7:0] s0, output logic [7:0] s1);
		wait_flag(`BIT_OUT_FULL, 1'b1);
		acc(5'h11, 8'h00);
		s0 = q;
		for (int i = 1; i < 8 && i < s0; i++) begin
			wait_flag(`BIT_OUT_FULL, 1'b1);
			acc(5'h11, 8'h00);
		end
		s1 = q;
	endtask
	// one byte per request or per ready bit
	task automatic xfer(input logic dma, input logic [4:0] k, input logic [7:0] d);
		if (dma) begin
			// looked at off the edge, once the registered request has settled
			for (int i = 0; i < 200 && i_dma_request !== 1'b1; i++) begin
				@(posedge i_clock);
				#1;
			end
			if (i_dma_request !== 1'b1) stalls++;
		end else begin
			wait_flag(`BIT_DRQ, 1'b1);
		end
		acc(k, d);
	endtask
endmodule

// [tb_tape_command_interface.sv]
// self-checking bench for the tape command interface
`timescale 1ns/1ps
`include "tape_cmd_defines.svh"
module tb_tape_command_interface;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	tape_cmd_pkg::mode_t i_mode = '0;
	tape_cmd_pkg::host_req_t i_host;
	logic [7:0] o_rdata, o_func_code, o_drive_data, s0, s1;
	logic irq, dreq, fstart, dd_rdy, od_valid;
	logic i_func_done = 1'b0;
	logic dd_valid = 1'b0;
	logic i_drive_data_ready = 1'b0;
	logic [7:0] i_drive_status = 8'h5A;
	logic [7:0] i_drive_data = 8'hC0;
	int err_total = 0;
	int checks = 0;
	int starts = 0;
	// rows: type b, code, parameter count, valid
	logic [12:0] rows [15] = '{13'h003, 13'h013, 13'h033, 13'h053, 13'h063, 13'h073, 13'h083,
		13'h093, 13'h0C2, 13'h402, 13'h1003, 13'h10C3, 13'h1143, 13'h117B, 13'h1052};
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) if (fstart === 1'b1) starts <= starts + 1;
	always @(posedge i_clock) if (dd_valid && dd_rdy === 1'b1) i_drive_data <= i_drive_data + 8'h01;
	tape_command_interface dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mode(i_mode),
		.i_host(i_host), .o_rdata(o_rdata), .o_end_of_function_interrupt(irq),
		.o_dma_request(dreq), .o_func_start(fstart), .o_func_code(o_func_code),
		.i_func_done(i_func_done), .i_drive_status(i_drive_status), .i_drive_data_valid(dd_valid),
		.i_drive_data(i_drive_data), .o_drive_data_ready(dd_rdy), .o_drive_data_valid(od_valid),
		.o_drive_data(o_drive_data), .i_drive_data_ready(i_drive_data_ready));
	tape_host_model host (.i_clock(i_clock), .i_rdata(o_rdata), .i_dma_request(dreq),
		.o_req(i_host));
	task automatic stop_test;
		err_total += host.stalls;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic restart(input tape_cmd_pkg::mode_t m);
		@(posedge i_clock);
		#1 i_sys_rst = 1'b1;
		i_mode = m;
		repeat (12) @(posedge i_clock);
		#1 i_sys_rst = 1'b0;
	endtask
	task automatic end_fn;
		@(posedge i_clock);
		#1 i_func_done = 1'b1;
		@(posedge i_clock);
		#1 i_func_done = 1'b0;
		cmp({7'h00, irq}, 8'h01);
	endtask
	task automatic simple(input logic b, input logic [7:0] c, input int n, input logic ok);
		int st;
		restart('{b, 1'b0});
		st = starts;
		host.send(c, n, 8'h00);
		if (ok) begin
			repeat (3) @(posedge i_clock);
			cmp(o_func_code, c);
			host.acc(5'h15, 8'h00);
			cmp(host.q, 8'h10);
			end_fn();
		end else begin
			host.acc(5'h15, 8'h00);
			cmp(host.q, 8'h19);
		end
		host.sense(s0, s1);
		cmp(8'(starts - st), {7'h00, ok});
		cmp(s0, {5'h00, `SENSE_COUNT});
		cmp(s1, ok ? i_drive_status : `ERR_INVALID);
	endtask
	initial begin
		#600000;
		err_total++;
		stop_test();
	end
	initial begin
		for (int r = 0; r < 15; r++) begin
			simple(rows[r][12], rows[r][11:4], int'(rows[r][3:1]), rows[r][0]);
		end
		// write in dma mode, fifo filled while the drive stalls
		restart('{1'b0, 1'b1});
		host.send(`OP_WRITE_BLOCK, 1, 8'h00);
		host.send(`OP_START_XFER, 1, 8'h00);
		host.acc(5'h15, 8'h00);
		cmp(host.q & 8'h01, 8'h00);
		for (int i = 0; i < 8; i++) host.xfer(1'b1, 5'h0A, 8'(i) + 8'hA0);
		@(posedge i_clock);
		#1 cmp({7'h00, dreq}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			cmp({7'h00, od_valid}, 8'h01);
			cmp(o_drive_data, 8'(i) + 8'hA0);
			@(posedge i_clock);
			#1 i_drive_data_ready = 1'b1;
			@(posedge i_clock);
			#1 i_drive_data_ready = 1'b0;
		end
		cmp({7'h00, od_valid}, 8'h00);
		cmp({7'h00, dreq}, 8'h01);
		host.send(`OP_END_XFER, 1, 8'h00);
		end_fn();
		host.sense(s0, s1);
		cmp(s1, i_drive_status);
		// polled read on the second drive type
		restart('{1'b1, 1'b0});
		host.send(`OP_READ_BLOCK, 3, 8'h00);
		host.send(`OP_START_XFER, 1, 8'h00);
		@(posedge i_clock);
		#1 cmp({7'h00, dd_rdy}, 8'h01);
		dd_valid = 1'b1;
		for (int i = 0; i < 3; i++) begin
			host.xfer(1'b0, 5'h09, 8'h00);
			cmp(host.q, 8'(i) + 8'hC0);
		end
		cmp({7'h00, dreq}, 8'h00);
		dd_valid = 1'b0;
		host.send(`OP_END_XFER, 1, 8'h00);
		end_fn();
		host.sense(s0, s1);
		cmp(s1, i_drive_status);
		stop_test();
	end
endmodule
